// *** pan_autoneg.sv ***
// Purpose: Auto-negotiation control and status for a gigabit or SGMII PCS.
// Assumes: Link receive indications are one-cycle pulses on the core clock.
// Notes:   Control and status are reached over a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
module pan_autoneg #(
	parameter int unsigned SGMII_CYC = pan_pkg::SGMII_CYC,
	parameter int unsigned GBE_CYC   = pan_pkg::GBE_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// Link receive side
	input  wire logic        sync_ok,
	input  wire logic        rx_config_valid,
	input  wire logic [15:0] rx_config_word,
	input  wire logic        rx_idle,
	// Link transmit side
	output var  logic [15:0] tx_config_word,
	output var  logic        tx_send_config,
	output var  logic        tx_send_idle,
	output var  logic        pcs_normal,
	// Status
	output var  logic [15:0] partner_ability_word,
	output var  logic        page_received,
	output var  logic        negotiation_done,
	output var  logic        irq
);
	localparam int unsigned TW = pan_pkg::TIMER_W;

	pan_pkg::pan_state_e state_r, state_nxt;
	logic [pan_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [15:0] adv_r, adv_nxt, lp_nxt, txw_nxt;
	logic [pan_pkg::IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
	logic        seen_r, seen_nxt, ack_nxt;
	logic [31:0] rd, wdat;
	logic [31:0] ctrl_wr, adv_wr, mask_wr;
	logic        req, wr, capture, moved;
	logic [TW-1:0] timer_len;
	logic        timer_done;
	logic        an_en, an_rst, phy_side, gbe, short_t;

	assign an_en    = ctrl_r[pan_pkg::CTRL_ENABLE];
	assign an_rst   = ctrl_r[pan_pkg::CTRL_RESTART];
	assign phy_side = ctrl_r[pan_pkg::CTRL_PHY];
	assign gbe      = ctrl_r[pan_pkg::CTRL_GBE];
	assign short_t  = ctrl_r[pan_pkg::CTRL_SHORT];
	assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// A write lands at the edge at which the master samples the acknowledge.
	assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	// Byte lanes of a write merged over the old register value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction

	// The debug short timer is meant for simulation only.
	always_comb
	begin
		if (short_t)
			timer_len = TW'(pan_pkg::SHORT_CYC);
		else if (gbe)
			timer_len = TW'(GBE_CYC);
		else
			timer_len = TW'(SGMII_CYC);
	end

	pan_link_timer #(
		.W (TW)
	) u_timer (
		.clk       (clk),
		.reset_n   (reset_n),
		.restart   (moved),
		.limit     (timer_len),
		.expired_r (timer_done)
	);

	// Negotiation sequence.
	always_comb
	begin
		state_nxt = state_r;
		if (!an_en)
			state_nxt = pan_pkg::ST_DISABLED;
		else if (an_rst || !sync_ok)
			state_nxt = pan_pkg::ST_RESTART;
		else
		begin
			unique case (state_r)
				pan_pkg::ST_DISABLED: state_nxt = pan_pkg::ST_RESTART;
				pan_pkg::ST_RESTART:  state_nxt = pan_pkg::ST_ABILITY;
				pan_pkg::ST_ABILITY:
					if (timer_done && seen_r)
						state_nxt = pan_pkg::ST_ACK_DET;
				pan_pkg::ST_ACK_DET:
					if (seen_r)
						state_nxt = pan_pkg::ST_CMPL_ACK;
				pan_pkg::ST_CMPL_ACK:
					if (timer_done)
						state_nxt = pan_pkg::ST_IDLE_DET;
				pan_pkg::ST_IDLE_DET:
					if (timer_done && seen_r)
						state_nxt = pan_pkg::ST_LINK_OK;
				pan_pkg::ST_LINK_OK:
					if (rx_config_valid)
						state_nxt = pan_pkg::ST_RESTART;
				default: state_nxt = pan_pkg::ST_RESTART;
			endcase
		end
	end

	assign moved = (state_nxt != state_r);
	assign capture = rx_config_valid && (state_r == pan_pkg::ST_ABILITY
		|| state_r == pan_pkg::ST_ACK_DET || state_r == pan_pkg::ST_CMPL_ACK);

	// Partner evidence collected since the current state was entered.
	always_comb
	begin
		seen_nxt = seen_r;
		lp_nxt   = partner_ability_word;
		if (capture)
			lp_nxt = rx_config_word;
		if (moved)
			seen_nxt = 1'b0;
		else if (state_r == pan_pkg::ST_ABILITY && rx_config_valid)
			seen_nxt = 1'b1;
		else if (state_r == pan_pkg::ST_ACK_DET && rx_config_valid
			&& rx_config_word[pan_pkg::ACK_BIT])
			seen_nxt = 1'b1;
		else if (state_r == pan_pkg::ST_IDLE_DET && rx_idle)
			seen_nxt = 1'b1;
	end

	// Transmit word: MAC side sends the fixed pattern, PHY side or GbE the local word.
	always_comb
	begin
		txw_nxt = (phy_side || gbe) ? adv_r : pan_pkg::MAC_WORD;
		txw_nxt[pan_pkg::ACK_BIT] = (state_nxt == pan_pkg::ST_ACK_DET)
			|| (state_nxt == pan_pkg::ST_CMPL_ACK);
		if (state_nxt == pan_pkg::ST_RESTART)
			txw_nxt = '0;
	end

	// Register bus and interrupt status.
	always_comb
	begin
		ctrl_nxt  = ctrl_r;
		adv_nxt   = adv_r;
		imask_nxt = imask_r;
		wdat      = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
		ctrl_wr   = merge({27'h000_0000, ctrl_r}, wb_dat_i, wb_sel_i);
		adv_wr    = merge({16'h0000, adv_r}, wb_dat_i, wb_sel_i);
		mask_wr   = merge({29'h0000_0000, imask_r}, wb_dat_i, wb_sel_i);
		ev        = '0;
		ev[pan_pkg::IRQ_PAGE] = moved && state_nxt == pan_pkg::ST_CMPL_ACK;
		ev[pan_pkg::IRQ_UP]   = moved && state_nxt == pan_pkg::ST_LINK_OK;
		ev[pan_pkg::IRQ_DOWN] = moved && state_r == pan_pkg::ST_LINK_OK;
		ist_nxt   = ist_r;
		if (wr)
		begin
			unique case (wb_adr_i)
				pan_pkg::REG_CTRL:
					ctrl_nxt = ctrl_wr[pan_pkg::CTRL_W-1:0];
				pan_pkg::REG_ADV:
					adv_nxt = adv_wr[15:0];
				pan_pkg::REG_IRQ_STAT:
					ist_nxt = ist_r & ~wdat[pan_pkg::IRQ_W-1:0];
				pan_pkg::REG_IRQ_MASK:
					imask_nxt = mask_wr[pan_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		ist_nxt = ist_nxt | ev;
		rd = 32'h0000_0000;
		unique case (wb_adr_i)
			pan_pkg::REG_CTRL:     rd = {27'h0, ctrl_r};
			pan_pkg::REG_ADV:      rd = {16'h0, adv_r};
			pan_pkg::REG_PARTNER:  rd = {16'h0, partner_ability_word};
			pan_pkg::REG_STATUS:   rd = {26'h0, timer_done, pcs_normal,
				state_r, 1'b0};
			pan_pkg::REG_IRQ_STAT: rd = {29'h0, ist_r};
			pan_pkg::REG_IRQ_MASK: rd = {29'h0, imask_r};
			default:               rd = 32'h0000_0000;
		endcase
	end
	assign ack_nxt = req;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r              <= pan_pkg::ST_DISABLED;
			seen_r               <= 1'b0;
			partner_ability_word <= 16'h0000;
			tx_config_word       <= 16'h0000;
			tx_send_config       <= 1'b0;
			tx_send_idle         <= 1'b0;
			pcs_normal           <= 1'b0;
			page_received        <= 1'b0;
			negotiation_done     <= 1'b0;
			ctrl_r               <= pan_pkg::CTRL_RESET;
			adv_r                <= pan_pkg::ADV_RESET;
			ist_r                <= '0;
			imask_r              <= '0;
			irq                  <= 1'b0;
			wb_ack_o             <= 1'b0;
			wb_dat_o             <= 32'h0000_0000;
		end
		else
		begin
			state_r              <= state_nxt;
			seen_r               <= seen_nxt;
			partner_ability_word <= lp_nxt;
			tx_config_word       <= txw_nxt;
			tx_send_config       <= state_nxt inside {pan_pkg::ST_RESTART,
				pan_pkg::ST_ABILITY, pan_pkg::ST_ACK_DET, pan_pkg::ST_CMPL_ACK};
			tx_send_idle         <= state_nxt inside {pan_pkg::ST_DISABLED,
				pan_pkg::ST_IDLE_DET, pan_pkg::ST_LINK_OK};
			pcs_normal           <= state_nxt == pan_pkg::ST_LINK_OK;
			page_received        <= state_nxt == pan_pkg::ST_CMPL_ACK;
			negotiation_done     <= state_nxt == pan_pkg::ST_LINK_OK;
			ctrl_r               <= ctrl_nxt;
			adv_r                <= adv_nxt;
			ist_r                <= ist_nxt;
			imask_r              <= imask_nxt;
			irq                  <= |(ist_nxt & imask_nxt);
			wb_ack_o             <= ack_nxt;
			wb_dat_o             <= ack_nxt ? rd : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_LP_CAPTURE: assert property (
		capture |=> partner_ability_word == $past(rx_config_word))
		else $error("Partner word not captured.");
	AST_DISABLED: assert property (
		!an_en |=> state_r == pan_pkg::ST_DISABLED && !tx_send_config)
		else $error("Negotiation ran while disabled.");
	AST_RESTART: assert property (
		an_en && an_rst |=> state_r == pan_pkg::ST_RESTART && tx_config_word == 16'h0000)
		else $error("Restart level ignored.");
	AST_PAGE_RX: assert property (
		page_received == (state_r == pan_pkg::ST_CMPL_ACK))
		else $error("Page-received does not track its state.");
	AST_DONE: assert property (
		$rose(negotiation_done) |-> $past(state_r) == pan_pkg::ST_IDLE_DET
			&& $past(timer_done) && $past(seen_r))
		else $error("Link OK entered without timer and idles.");
	AST_MAC_WORD: assert property (
		tx_send_config && !$past(phy_side) && !$past(gbe)
			&& state_r != pan_pkg::ST_RESTART |-> tx_config_word[13:0] == 14'h0001)
		else $error("MAC-side word wrong.");
	AST_TIMER_LEN: assert property (
		!short_t |-> timer_len == (gbe ? TW'(GBE_CYC) : TW'(SGMII_CYC)))
		else $error("Normal timer length wrong.");
	AST_SHORT: assert property (
		short_t |-> timer_len == TW'(pan_pkg::T_SHORT_NS / pan_pkg::CLK_PERIOD_NS))
		else $error("Short timer length wrong.");
	AST_ACK_ENTRY: assert property (
		state_r == pan_pkg::ST_ABILITY ##1 state_r == pan_pkg::ST_ACK_DET
			|-> $past(timer_done) && tx_config_word[pan_pkg::ACK_BIT])
		else $error("Acknowledge sent before timer expiry.");
	AST_IDLE_ENTRY: assert property (
		$rose(state_r == pan_pkg::ST_IDLE_DET) |-> $past(timer_done) && tx_send_idle)
		else $error("Idles sent before timer expiry.");
	AST_NORMAL: assert property (
		negotiation_done && !rx_config_valid && an_en && !an_rst && sync_ok
			|=> negotiation_done && pcs_normal)
		else $error("Link OK left without a restart event.");
	AST_LP_HOLD: assert property (
		!capture |=> $stable(partner_ability_word))
		else $error("Partner word changed without a new word.");
	AST_WB_ACK: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("Bus acknowledge held too long.");
	AST_WB_ANSWER: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request not answered in one cycle.");
	AST_IRQ_LEVEL: assert property (
		irq == |(ist_r & imask_r))
		else $error("Interrupt line does not match unmasked status.");
	AST_UP_EVENT: assert property (
		state_r != pan_pkg::ST_LINK_OK ##1 state_r == pan_pkg::ST_LINK_OK
			|-> ist_r[pan_pkg::IRQ_UP])
		else $error("Link-up event lost.");
	AST_TX_EXCL: assert property (
		!(tx_send_config && tx_send_idle))
		else $error("Config words and idles sent together.");

	COV_LINK_UP: cover property ($rose(negotiation_done));
	COV_PAGE: cover property ($rose(page_received));
	COV_RELINK: cover property (negotiation_done ##1 state_r == pan_pkg::ST_RESTART);
	COV_IRQ: cover property ($rose(irq));
	COV_ENABLE: cover property ($fell(state_r == pan_pkg::ST_DISABLED));
endmodule
`default_nettype wire

// *** pan_pkg.sv ***
// Functional notes
// - Output the sixteen-bit ability word last received from the link partner; code updates it only in ability, ack-detect and complete-ack states.
// - Negotiation runs only while the enable is high; low stops it.
// - A high restart level sends the negotiation back to its start.
// - Page-received is high exactly while in the complete-acknowledge state.
// - Negotiation-done is high exactly while in the link-OK state.
// - Side select 0 gives MAC-side behaviour, 1 gives PHY-side behaviour; in 1000BASE-X mode the code sends the local word for either setting.
// - Normal link timer lasts 1.6 ms for SGMII and 10 ms for 1000BASE-X.
// - Short-timer select high cuts the link timer to 2 us for debug.
// - On a trigger send abilities; after timer expiry acknowledge partner abilities.
// - After expiry and partner ack send idles; after expiry and idles, link OK.
// - Stay in link-OK until restart; normal coding runs only in link-OK.
//
// Purpose: Constants shared by the auto-negotiation control block.
// Assumes: 100 MHz core clock.
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone bus.
`default_nettype none
package pan_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_SGMII_NS    = 1_600_000;
	localparam int unsigned T_GBE_NS      = 10_000_000;
	localparam int unsigned T_SHORT_NS    = 2_000;
	localparam int unsigned SGMII_CYC     = T_SGMII_NS / CLK_PERIOD_NS;
	localparam int unsigned GBE_CYC       = T_GBE_NS / CLK_PERIOD_NS;
	localparam int unsigned SHORT_CYC     = T_SHORT_NS / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W       = 20;

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_ADV      = 8'h04;
	localparam logic [7:0] REG_PARTNER  = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;

	localparam int unsigned CTRL_ENABLE  = 0;
	localparam int unsigned CTRL_RESTART = 1;
	localparam int unsigned CTRL_PHY     = 2;
	localparam int unsigned CTRL_GBE     = 3;
	localparam int unsigned CTRL_SHORT   = 4;
	localparam int unsigned CTRL_W       = 5;
	localparam logic [4:0]  CTRL_RESET   = 5'h01;
	localparam logic [15:0] ADV_RESET    = 16'h0001;

	localparam int unsigned ACK_BIT      = 14;
	localparam logic [15:0] MAC_WORD     = 16'h4001;

	localparam int unsigned IRQ_PAGE     = 0;
	localparam int unsigned IRQ_UP       = 1;
	localparam int unsigned IRQ_DOWN     = 2;
	localparam int unsigned IRQ_W        = 3;

	typedef enum logic [2:0] {
		ST_DISABLED = 3'b000,
		ST_RESTART  = 3'b001,
		ST_ABILITY  = 3'b010,
		ST_ACK_DET  = 3'b011,
		ST_CMPL_ACK = 3'b100,
		ST_IDLE_DET = 3'b101,
		ST_LINK_OK  = 3'b110
	} pan_state_e;
endpackage
`default_nettype wire

// *** pan_link_timer.sv ***
// Purpose: Link interval timer for the auto-negotiation machine.
// Assumes: limit is at least one and stays stable between restarts.
// Notes:   Expiry is sticky until the next restart.
`timescale 1ns/1ps
`default_nettype none
module pan_link_timer #(
	parameter int unsigned W = 20
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Control
	input  wire logic         restart,
	input  wire logic [W-1:0] limit,
	// Status
	output var  logic         expired_r
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;
	logic         expired_nxt;

	always_comb
	begin
		count_nxt   = count_r;
		expired_nxt = expired_r;
		if (restart)
		begin
			count_nxt   = '0;
			expired_nxt = 1'b0;
		end
		else if (!expired_r)
		begin
			if (count_r == limit - W'(1))
				expired_nxt = 1'b1;
			else
				count_nxt = count_r + W'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_r   <= '0;
			expired_r <= 1'b0;
		end
		else
		begin
			count_r   <= count_nxt;
			expired_r <= expired_nxt;
		end
	end

	AST_TIMER_EXACT: assert property (@(posedge clk) disable iff (!reset_n)
		restart ##1 (!restart)[*2] |-> !expired_r || limit <= W'(2))
		else $error("Link timer expired too early.");
endmodule
`default_nettype wire

// *** pan_partner.sv ***
// Purpose: Link partner model that takes part in the negotiation over the link.
// Assumes: One core clock; receive indications are one-cycle pulses.
// Notes:   no_ack keeps the acknowledge bit clear so the far side stalls.
`timescale 1ns/1ps
`default_nettype none
module pan_partner (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Bench control
	input  wire logic [15:0] ability,
	input  wire logic [7:0]  gap,
	input  wire logic        no_ack,
	// Device transmit side
	input  wire logic        tx_send_config,
	input  wire logic [15:0] tx_config_word,
	input  wire logic        tx_send_idle,
	// Device receive side
	output var  logic        rx_config_valid,
	output var  logic [15:0] rx_config_word,
	output var  logic        rx_idle
);
	logic [7:0]  cnt_r;
	logic        seen_r;
	logic [15:0] last_r;
	// Between words the line shows the inverse of the last word, never a held value.
	assign rx_config_word = rx_config_valid ? last_r : ~last_r;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_r <= 8'h00;
			seen_r <= 1'b0;
			last_r <= 16'h0000;
			rx_config_valid <= 1'b0;
			rx_idle <= 1'b0;
		end
		else
		begin
			cnt_r <= (cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
			if (tx_send_config)
				seen_r <= (tx_config_word != 16'h0000);
			rx_config_valid <= (cnt_r == 8'h00) && tx_send_config;
			rx_idle <= (cnt_r == 8'h00) && tx_send_idle;
			if ((cnt_r == 8'h00) && tx_send_config)
				last_r <= {ability[15], seen_r & ~no_ack, ability[13:0]};
		end
	end
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the auto-negotiation control block.
// Assumes: Shortened link timers by parameter; partner model on the link.
// Notes:   Register cases run from a table; link scenarios follow it.
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] wd;
		logic [31:0] rd;
	} pan_row_s;
	localparam int L_SG = 50;
	localparam int L_GB = 80;
	localparam int L_SH = pan_pkg::SHORT_CYC;
	localparam logic [31:0] CTL [3] = '{32'h0000_0001, 32'h0000_000D, 32'h0000_0015};
	localparam int LIM [3] = '{L_SG, L_GB, L_SH};
	localparam logic [7:0] GAPS [3] = '{8'h03, 8'h11, 8'h05};
	localparam logic [15:0] EXPW [3] = '{16'h4001, 16'hEB12, 16'hEB12};
	localparam pan_row_s ROWS [15] = '{
		'{1'h0, 8'h00, 4'hF, 32'h0000_0000, 32'h0000_0001},
		'{1'h0, 8'h04, 4'hF, 32'h0000_0000, 32'h0000_0001},
		'{1'h0, 8'h08, 4'hF, 32'h0000_0000, 32'h0000_0000},
		'{1'h0, 8'h10, 4'hF, 32'h0000_0000, 32'h0000_0000},
		'{1'h0, 8'h14, 4'hF, 32'h0000_0000, 32'h0000_0000},
		'{1'h1, 8'h04, 4'hF, 32'h0000_ABCD, 32'h0000_0000},
		'{1'h1, 8'h04, 4'h1, 32'h0000_0012, 32'h0000_0000},
		'{1'h0, 8'h04, 4'hF, 32'h0000_0000, 32'h0000_AB12},
		'{1'h1, 8'h08, 4'hF, 32'h0000_5555, 32'h0000_0000},
		'{1'h0, 8'h08, 4'hF, 32'h0000_0000, 32'h0000_0000},
		'{1'h1, 8'h20, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
		'{1'h0, 8'h20, 4'hF, 32'h0000_0000, 32'h0000_0000},
		'{1'h1, 8'h14, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
		'{1'h0, 8'h14, 4'hF, 32'h0000_0000, 32'h0000_0007},
		'{1'h1, 8'h14, 4'hF, 32'h0000_0000, 32'h0000_0000}};
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic        sync_ok = 1'b0;
	logic        no_ack = 1'b0;
	logic [7:0]  gap = 8'h03;
	logic [3:0]  lanes = 4'hF;
	logic [31:0] rdat, q;
	logic        ack, cv, idl, tsc, tsi, pcs, pg, done, irq, pg_seen, pg_prev;
	logic [15:0] cw, tcw, paw, pg_word;
	int          bad_count = 0;
	int          n_tests = 0;
	int          span = 0;
	always #5 clk = ~clk;
	pan_autoneg #(.SGMII_CYC(L_SG), .GBE_CYC(L_GB)) i_pan_autoneg (
		.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sync_ok(sync_ok), .rx_config_valid(cv), .rx_config_word(cw), .rx_idle(idl),
		.tx_config_word(tcw), .tx_send_config(tsc), .tx_send_idle(tsi), .pcs_normal(pcs),
		.partner_ability_word(paw), .page_received(pg), .negotiation_done(done), .irq(irq));
	pan_partner i_pan_partner (
		.clk(clk), .reset_n(reset_n), .ability(16'h0021), .gap(gap), .no_ack(no_ack),
		.tx_send_config(tsc), .tx_config_word(tcw), .tx_send_idle(tsi),
		.rx_config_valid(cv), .rx_config_word(cw), .rx_idle(idl));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= lanes;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			chk("wb_ack", 0, 1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_done(input int lim);
		int n = 0;
		while (done !== 1'b1 && n < 4 * lim + 200)
		begin
			@(posedge clk);
			n++;
		end
		chk("done", done, 1);
	endtask
	// Measures how long page_received stays high and what is sent meanwhile.
	always @(posedge clk)
	begin
		if (pg === 1'b1)
		begin
			if (pg_prev !== 1'b1)
				span = 0;
			span++;
			pg_seen = 1'b1;
			pg_word = tcw;
		end
		pg_prev = pg;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		chk("watchdog", 0, 1);
		give_verdict();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		chk("done_in_reset", {pg, done, pcs, irq}, 0);
		reset_n <= 1'b1;
		foreach (ROWS[i])
		begin
			lanes = ROWS[i].sel;
			wb(ROWS[i].we, ROWS[i].adr, ROWS[i].wd);
			if (!ROWS[i].we)
				chk("reg", q, ROWS[i].rd);
		end
		lanes = 4'hF;
		$display("test registers done");
		sync_ok <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			gap <= GAPS[i];
			pg_seen = 1'b0;
			wb(1'b1, 8'h00, CTL[i] | 32'h0000_0002);
			wb(1'b0, 8'h0C, 32'h0000_0000);
			chk("restart_state", q[3:1], 1);
			wb(1'b1, 8'h00, CTL[i]);
			wait_done(LIM[i]);
			chk("pcs", pcs, 1);
			chk("idle_tx", tsi, 1);
			chk("page_seen", pg_seen, 1);
			chk("page_now", pg, 0);
			chk("ack_word", pg_word, EXPW[i]);
			chk("interval", span >= LIM[i] && span <= LIM[i] + 2, 1);
			chk("partner", paw, 16'h4021);
			wb(1'b0, 8'h0C, 32'h0000_0000);
			chk("link_state", q[3:1], 6);
			chk("link_pcs", q[4], 1);
			$display("test mode %0d done", i);
		end
		wb(1'b1, 8'h10, 32'h0000_0007);
		sync_ok <= 1'b0;
		repeat (4) @(posedge clk);
		chk("down_done", {done, pcs}, 0);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("irq_stat", q, 32'h0000_0004);
		chk("irq_masked", irq, 0);
		wb(1'b1, 8'h14, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk("irq_on", irq, 1);
		wb(1'b1, 8'h10, 32'h0000_0004);
		repeat (2) @(posedge clk);
		chk("irq_off", irq, 0);
		chk("partner_hold", paw, 16'h4021);
		$display("test interrupt done");
		sync_ok <= 1'b1;
		wb(1'b1, 8'h00, 32'h0000_0014);
		repeat (900) @(posedge clk);
		chk("dis_done", {done, tsc}, 0);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk("dis_state", q[3:1], 0);
		wb(1'b1, 8'h00, 32'h0000_0015);
		wait_done(L_SH);
		$display("test enable done");
		no_ack <= 1'b1;
		pg_seen = 1'b0;
		wb(1'b1, 8'h00, 32'h0000_0017);
		wb(1'b1, 8'h00, 32'h0000_0015);
		repeat (1000) @(posedge clk);
		chk("stall_page", pg_seen, 0);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk("stall_state", q[3:1], 3);
		chk("stall_word", paw, 16'h0021);
		no_ack <= 1'b0;
		wait_done(L_SH);
		$display("test acknowledge done");
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("partner_rst", paw, 0);
		reset_n <= 1'b1;
		wait_done(L_SG);
		chk("partner_new", paw, 16'h4021);
		$display("test reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
